// file: pin_function_pkg.sv
// Constants for the flash pin function and protection control block
package pin_function_pkg;
	// Status protection field positions within the write data byte
	localparam int unsigned SWD_BIT = 7;
	localparam int unsigned QE_BIT = 6;
	localparam int unsigned BP3_BIT = 5;
	localparam int unsigned BP0_BIT = 2;
	localparam int unsigned PROT_W = 6;
	localparam logic [5:0] PROT_RESET = 6'h00;
	localparam logic HOLD_RESET_SEL_RESET = 1'b0;
	localparam logic FUNC_REG_RESET = 1'b0;
	// Bit of the function configuration that disables the dedicated reset
	localparam int unsigned FUNC_RST_DIS_BIT = 0;
	// Reset cycles still held after the reset pin releases
	localparam int unsigned RST_HOLD_CYC = 1;
	typedef enum logic [1:0] {
		SHARED_PAUSE,
		SHARED_RESET,
		SHARED_LANE3
	} shared_fn_e;
endpackage : pin_function_pkg

// file: pin_function_decode.sv
// Function decode for the two shared multi-function pins
`timescale 1ns/1ps
`default_nettype none
module pin_function_decode
	import pin_function_pkg::*;
(
	input wire logic quad_enable_i,
	input wire logic hold_reset_select_i,
	input wire logic dedicated_pin_present_i,
	input wire logic dedicated_rst_disable_i,
	output logic wp_active_o,
	output shared_fn_e shared_fn_o
);
	always_comb begin
		wp_active_o = ~quad_enable_i; // [R3]
		if (quad_enable_i) begin
			shared_fn_o = SHARED_LANE3; // [R4]
		end else if (dedicated_pin_present_i && !dedicated_rst_disable_i) begin
			shared_fn_o = SHARED_PAUSE; // [R6]
		end else if (hold_reset_select_i) begin
			shared_fn_o = SHARED_RESET; // [R5] [R7]
		end else begin
			shared_fn_o = SHARED_PAUSE; // [R5] [R7]
		end
	end
endmodule : pin_function_decode
`default_nettype wire

// file: flash_pin_function_protect_ctrl.sv
// Pin function muxing, write protection, pause and hardware reset control
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Refuse protection bit writes when write disable is 1 and protect pin low.
// [R2] Write disable 0 lets status writes through whatever the protect pin level.
// [R3] Quad enable 1 turns protect pin into data lane 2 only.
// [R4] Quad enable 1 turns shared pin into data lane 3 only.
// [R5] No dedicated reset pin: select bit picks pause (0) or reset (1).
// [R6] Dedicated reset enabled: shared pin is always pause when quad off.
// [R7] Dedicated reset disabled: select bit picks pause or reset.
// [R8] Pause low while selected puts serial output in high impedance.
// [R9] Pause freezes the transaction and resumes from the same point.
// [R10] Hardware reset low holds reset with outputs high impedance.
// [R11] Function configuration bit 0 set disables the dedicated reset pin.
// [R12] Host avoids hardware reset during internal write, program or erase.
// [R13] Chip select high deselects, ignores data, outputs high impedance.
// [R14] Shared pin in reset role acts like the dedicated reset pin.
module flash_pin_function_protect_ctrl
	import pin_function_pkg::*;
#(
	parameter bit DEDICATED_RESET_PIN = 1'b1
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic chip_select_n_i,
	input wire logic write_protect_n_i,
	input wire logic shared_pin_i,
	input wire logic dedicated_reset_n_i,
	input wire logic status_wr_i,
	input wire logic [7:0] status_wr_data_i,
	input wire logic cfg_wr_i,
	input wire logic hold_reset_select_wr_i,
	input wire logic func_wr_i,
	input wire logic func_rst_disable_i,
	input wire logic core_out_en_i,
	input wire logic so_en_i,
	input wire logic lane2_out_i,
	input wire logic lane3_out_i,
	output logic status_write_disable_o,
	output logic quad_enable_o,
	output logic [3:0] block_protect_o,
	output logic hold_reset_select_o,
	output logic func_rst_disable_o,
	output logic status_wr_refused_o,
	output logic wp_active_o,
	output logic [1:0] shared_fn_o,
	output logic pause_o,
	output logic core_run_o,
	output logic device_reset_o,
	output logic so_oe_n_o,
	output logic lane2_oe_n_o,
	output logic lane3_oe_n_o,
	output logic lane2_o,
	output logic lane3_o
);
	logic [5:0] prot_q, prot_d;
	logic hrs_q, hrs_d;
	logic frd_q, frd_d;
	logic refused_q, refused_d;
	logic rst_q, rst_d;
	logic l2_q, l2_d, l3_q, l3_d;
	logic wp_act;
	shared_fn_e sfn;
	logic selected, pause_lvl, pin_rst, wr_blocked;

	pin_function_decode u_decode (
		.quad_enable_i(prot_q[QE_BIT-2]),
		.hold_reset_select_i(hrs_q),
		.dedicated_pin_present_i(DEDICATED_RESET_PIN),
		.dedicated_rst_disable_i(frd_q),
		.wp_active_o(wp_act),
		.shared_fn_o(sfn)
	);

	always_comb begin
		selected = ~chip_select_n_i; // [R13]
		pause_lvl = (sfn == SHARED_PAUSE) && !shared_pin_i && selected;
		// Dedicated pin counts only when present and not disabled
		pin_rst = (DEDICATED_RESET_PIN && !frd_q && !dedicated_reset_n_i)
			|| ((sfn == SHARED_RESET) && !shared_pin_i); // [R11] [R14]
		wr_blocked = prot_q[SWD_BIT-2] && wp_act
			&& !write_protect_n_i; // [R1] [R2] [R3]
	end

	always_comb begin
		prot_d = prot_q;
		hrs_d = hrs_q;
		frd_d = frd_q;
		refused_d = 1'b0;
		rst_d = pin_rst;
		l2_d = lane2_out_i;
		l3_d = lane3_out_i;
		// Pin reset blocks writes from its first cycle, not one later
		if (rst_q || pin_rst) begin
			rst_d = pin_rst; // [R10]
		end else if (selected && !pause_lvl) begin
			// Writes only land while selected and not paused
			if (status_wr_i) begin
				if (wr_blocked) begin
					refused_d = 1'b1; // [R1]
				end else begin
					prot_d = status_wr_data_i[SWD_BIT:BP0_BIT]; // [R2]
				end
			end
			if (cfg_wr_i) begin
				hrs_d = hold_reset_select_wr_i;
			end
			if (func_wr_i) begin
				frd_d = func_rst_disable_i; // [R11]
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			prot_q <= PROT_RESET;
			hrs_q <= HOLD_RESET_SEL_RESET;
			frd_q <= FUNC_REG_RESET;
			refused_q <= 1'b0;
			rst_q <= 1'b0;
			l2_q <= 1'b0;
			l3_q <= 1'b0;
		end else begin
			prot_q <= prot_d;
			hrs_q <= hrs_d;
			frd_q <= frd_d;
			refused_q <= refused_d;
			rst_q <= rst_d;
			l2_q <= l2_d;
			l3_q <= l3_d;
		end
	end

	// Output enables are combinational so high impedance is immediate
	always_comb begin
		status_write_disable_o = prot_q[SWD_BIT-2];
		quad_enable_o = prot_q[QE_BIT-2];
		block_protect_o = prot_q[BP3_BIT-2:0];
		hold_reset_select_o = hrs_q;
		func_rst_disable_o = frd_q;
		status_wr_refused_o = refused_q;
		wp_active_o = wp_act;
		shared_fn_o = sfn;
		pause_o = pause_lvl; // [R8]
		device_reset_o = rst_q | pin_rst; // [R10] [R14]
		// Sequence state stays frozen, not cleared, during pause
		core_run_o = selected && !pause_lvl && !device_reset_o; // [R9]
		so_oe_n_o = !(core_run_o && so_en_i && core_out_en_i); // [R8] [R13]
		lane2_oe_n_o = !(core_run_o && !wp_act && core_out_en_i); // [R3]
		lane3_oe_n_o = !(core_run_o && (sfn == SHARED_LANE3)
			&& core_out_en_i); // [R4]
		lane2_o = l2_q;
		lane3_o = l3_q;
	end

	property p_refuse;
		@(posedge mclk_i) disable iff (reset_i)
		(status_wr_i && wr_blocked && core_run_o)
			|=> (status_wr_refused_o && $stable(prot_q));
	endproperty
	a_refuse: assert property (p_refuse) else $error("protected write accepted"); // [R1]
	property p_accept;
		@(posedge mclk_i) disable iff (reset_i)
		(status_wr_i && !prot_q[SWD_BIT-2] && core_run_o)
			|=> (prot_q == $past(status_wr_data_i[SWD_BIT:BP0_BIT]));
	endproperty
	a_accept: assert property (p_accept) else $error("status write lost"); // [R2]
	property p_lane2;
		@(posedge mclk_i) disable iff (reset_i)
		quad_enable_o |-> !wp_active_o;
	endproperty
	a_lane2: assert property (p_lane2) else $error("protect pin active in quad"); // [R3]
	property p_lane3;
		@(posedge mclk_i) disable iff (reset_i)
		quad_enable_o |-> (shared_fn_o == SHARED_LANE3) && !pause_o;
	endproperty
	a_lane3: assert property (p_lane3) else $error("shared pin not lane 3"); // [R4]
	property p_sel;
		@(posedge mclk_i) disable iff (reset_i)
		(!quad_enable_o && (!DEDICATED_RESET_PIN || frd_q))
			|-> (shared_fn_o == (hrs_q ? SHARED_RESET : SHARED_PAUSE));
	endproperty
	a_sel: assert property (p_sel) else $error("select bit ignored"); // [R5]
	property p_fixed_pause;
		@(posedge mclk_i) disable iff (reset_i)
		(!quad_enable_o && DEDICATED_RESET_PIN && !frd_q)
			|-> (shared_fn_o == SHARED_PAUSE);
	endproperty
	a_fixed_pause: assert property (p_fixed_pause) else $error("not pause"); // [R6]
	property p_pause_hiz;
		@(posedge mclk_i) disable iff (reset_i)
		pause_o |-> so_oe_n_o ##1 $stable(prot_q);
	endproperty
	a_pause_hiz: assert property (p_pause_hiz) else $error("output during pause"); // [R8]
	property p_rst_hiz;
		@(posedge mclk_i) disable iff (reset_i)
		device_reset_o |-> so_oe_n_o && lane2_oe_n_o && lane3_oe_n_o;
	endproperty
	a_rst_hiz: assert property (p_rst_hiz) else $error("output in reset"); // [R10]
	property p_desel;
		@(posedge mclk_i) disable iff (reset_i)
		chip_select_n_i |-> so_oe_n_o ##1 $stable(prot_q);
	endproperty
	a_desel: assert property (p_desel) else $error("deselected activity"); // [R13]
	property p_shared_rst;
		@(posedge mclk_i) disable iff (reset_i)
		((shared_fn_o == SHARED_RESET) && !shared_pin_i) |-> device_reset_o;
	endproperty
	a_shared_rst: assert property (p_shared_rst) else $error("no shared reset"); // [R14]
	c_refused: cover property (@(posedge mclk_i) status_wr_refused_o);
	c_pause: cover property (@(posedge mclk_i) pause_o ##1 !pause_o);
	c_quad: cover property (@(posedge mclk_i) quad_enable_o);
	c_shrst: cover property (@(posedge mclk_i) shared_fn_o == SHARED_RESET);
endmodule : flash_pin_function_protect_ctrl
`default_nettype wire

// file: host_ctrl_model.sv
// Host side pin driver for select, protect, shared and reset pins
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
	input wire logic mclk_i,
	output logic cs_n_o,
	output logic wp_n_o,
	output logic shared_o,
	output logic rst_n_o
);
	initial begin
		{cs_n_o, wp_n_o, shared_o, rst_n_o} = 4'b1111;
	end
	// Pins move just after an edge; reset only outside writes
	task automatic drive(input logic [3:0] p);
		@(posedge mclk_i);
		#1;
		{cs_n_o, wp_n_o, shared_o, rst_n_o} = p;
		// Let decode settle before the caller looks
		#1;
	endtask : drive
endmodule : host_ctrl_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the pin function and protection block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pin_function_pkg::*;
	logic mclk_i, reset_i, cs_n, wp_n, sh, rst_n, sw, cw, fw, swd, qe;
	logic hrs, fdis, refused, wp_act, pause, run, dev_rst, so_oe_n;
	logic oe, soe, l2i, l3i, l2oe_n, l3oe_n, l2o, l3o;
	logic [7:0] d;
	logic [3:0] bp;
	logic [1:0] fn;
	int err_total = 0;
	int num_checks = 0;
	initial begin
		mclk_i = 0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	host_ctrl_model u_host_ctrl_model (.mclk_i(mclk_i), .cs_n_o(cs_n),
		.wp_n_o(wp_n), .shared_o(sh), .rst_n_o(rst_n));
	flash_pin_function_protect_ctrl u_flash_pin_function_protect_ctrl (
		.mclk_i(mclk_i), .reset_i(reset_i), .chip_select_n_i(cs_n),
		.write_protect_n_i(wp_n), .shared_pin_i(sh),
		.dedicated_reset_n_i(rst_n), .status_wr_i(sw),
		.status_wr_data_i(d), .cfg_wr_i(cw), .hold_reset_select_wr_i(d[0]),
		.func_wr_i(fw), .func_rst_disable_i(d[0]), .core_out_en_i(oe),
		.so_en_i(soe), .lane2_out_i(l2i), .lane3_out_i(l3i),
		.status_write_disable_o(swd), .quad_enable_o(qe),
		.block_protect_o(bp), .hold_reset_select_o(hrs),
		.func_rst_disable_o(fdis), .status_wr_refused_o(refused),
		.wp_active_o(wp_act), .shared_fn_o(fn), .pause_o(pause),
		.core_run_o(run), .device_reset_o(dev_rst), .so_oe_n_o(so_oe_n),
		.lane2_oe_n_o(l2oe_n), .lane3_oe_n_o(l3oe_n), .lane2_o(l2o),
		.lane3_o(l3o));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// Kind 0 status, 1 select bit, 2 function bit
	task automatic wr(input int k, input logic [7:0] v);
		@(posedge mclk_i);
		#1;
		d = v;
		{sw, cw, fw} = 3'b100 >> k;
		@(posedge mclk_i);
		#1;
		{sw, cw, fw} = 3'b000;
	endtask : wr
	task automatic t_protect;
		int n;
		u_host_ctrl_model.drive(4'b0011);
		wr(0, 8'h80);
		chk(8'(swd), 8'h01);
		wr(0, 8'h3C);
		n = 0;
		while (refused !== 1'b1 && n < 3) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk(8'(refused), 8'h01);
		if (refused !== 1'b1)
			stop_test();
		chk(8'(bp), 8'h00);
		u_host_ctrl_model.drive(4'b0111);
		wr(0, 8'h3C);
		chk(8'({swd, bp}), 8'h0F);
		wr(0, 8'hC0);
		chk(8'(fn), 8'(SHARED_LANE3));
		chk(8'({wp_act, l2oe_n, l3oe_n}), 8'h00);
		{l2i, l3i} = 2'b10;
		@(posedge mclk_i);
		#1;
		chk(8'({l2o, l3o}), 8'h02);
		u_host_ctrl_model.drive(4'b0101);
		chk(8'({pause, run}), 8'h01);
		u_host_ctrl_model.drive(4'b0011);
		wr(0, 8'h00);
		chk(8'(qe), 8'h00);
		$display("protect done");
	endtask : t_protect
	task automatic t_shared;
		u_host_ctrl_model.drive(4'b1011);
		wr(0, 8'h80);
		chk(8'({swd, so_oe_n, l2oe_n, l3oe_n}), 8'h07);
		u_host_ctrl_model.drive(4'b0011);
		wr(1, 8'h01);
		chk(8'(fn), 8'(SHARED_PAUSE));
		wr(2, 8'h01);
		chk(8'(fn), 8'(SHARED_RESET));
		u_host_ctrl_model.drive(4'b0010);
		chk(8'({dev_rst, run}), 8'h01);
		u_host_ctrl_model.drive(4'b0001);
		chk(8'({dev_rst, run, pause}), 8'h04);
		u_host_ctrl_model.drive(4'b0011);
		wr(2, 8'h00);
		wr(1, 8'h00);
		chk(8'({hrs, fdis}), 8'h00);
		$display("shared done");
	endtask : t_shared
	task automatic t_pause;
		u_host_ctrl_model.drive(4'b0001);
		chk(8'({pause, so_oe_n, run}), 8'h06);
		wr(0, 8'h80);
		chk(8'(swd), 8'h00);
		u_host_ctrl_model.drive(4'b0011);
		chk(8'({run, so_oe_n}), 8'h02);
		soe = 1'b0;
		@(posedge mclk_i);
		#1;
		chk(8'(so_oe_n), 8'h01);
		{soe, oe} = 2'b10;
		@(posedge mclk_i);
		#1;
		chk(8'(so_oe_n), 8'h01);
		oe = 1'b1;
		u_host_ctrl_model.drive(4'b0010);
		chk(8'({dev_rst, so_oe_n}), 8'h03);
		u_host_ctrl_model.drive(4'b0011);
		chk(8'({dev_rst, run}), 8'h02);
		repeat (RST_HOLD_CYC) @(posedge mclk_i);
		#1;
		chk(8'(run), 8'h01);
		$display("pause and reset done");
	endtask : t_pause
	initial begin
		reset_i = 1;
		{sw, cw, fw} = 3'b000;
		{oe, soe, l2i, l3i} = 4'b1100;
		d = 8'h00;
		repeat (8) @(posedge mclk_i);
		#1;
		reset_i = 0;
		chk({swd, qe, bp, hrs, fdis}, 8'h00);
		chk(8'({so_oe_n, l2oe_n, l3oe_n, l2o, l3o}), 8'h1C);
		t_protect();
		t_shared();
		t_pause();
		stop_test();
	end
endmodule : tb
`default_nettype wire
